// ==== testbench/pin_pad_model.sv ====
// Board side of the package pins: resolves each pin level.
// Assumes the design drives a pin only while its enable is high.
`timescale 1ns/1ps
`default_nettype none
module pin_pad_model (
  // Design side, flat pin index
  input wire logic [pin_mux_pkg::NUM_PINS-1:0] drv_i,
  input wire logic [pin_mux_pkg::NUM_PINS-1:0] oe_i,
  // Board side
  input wire logic [pin_mux_pkg::NUM_PINS-1:0] ext_i,
  output logic [pin_mux_pkg::NUM_PINS-1:0] pin_o
);
  import pin_mux_pkg::*;
  // Board backs off while the device drives, so no contention
  assign pin_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule
`default_nettype wire

// ==== testbench/tb_port_pin_mux.sv ====
// Self-checking bench for the four-port pin function router.
// Assumes pin_pad_model closes the pin loop; config held 8 cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_port_pin_mux;
  import pin_mux_pkg::*;
  localparam int WD_CYCLES = 2000;
  localparam int AW = NUM_PINS * NALT;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [NUM_PINS-1:0] dout = '0, dir = '0, en = '0, ext = '0;
  logic [NUM_PINS-1:0] n_en = '0, din, bad, pin, f_out, f_oe;
  logic [NUM_PINS*SEL_W-1:0] sel = '0, n_sel = '0;
  logic [AW-1:0] a_out = '0, a_oe = '0, a_in;
  logic rr = 1'b0, rt = 1'b0, ce = 1'b0, n_rr = 1'b0, n_rt = 1'b0;
  logic n_ce = 1'b0;
  logic own_r, own_t, rst_n, ck_in, ck_rt, ck_cf;
  logic [7:0] pa_o, pa_e, pb_o, pb_e;
  logic [6:0] pc_o, pc_e, pc_i;
  logic [3:0] pd_o, pd_e;
  logic [NUM_PINS-1:0] h_pin [3];
  int fail_count = 0;
  int check_count = 0;
  int seed = 51820;
  int cnt = 0;

  always #4 clk_i = ~clk_i;
  assign f_out = {pd_o, pc_o[6:4], pc_o[2:0], pb_o, pa_o};
  assign f_oe = {pd_e, pc_e[6:4], pc_e[2:0], pb_e, pa_e};
  // Hole at C3 is fed a constant; the design ignores it
  assign pc_i = {pin[21:19], 1'b0, pin[18:16]};

  pin_pad_model pad_u (.drv_i(f_out), .oe_i(f_oe), .ext_i(ext),
    .pin_o(pin));

  port_pin_mux dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .pin_a_in_i(pin[7:0]), .pin_a_out_o(pa_o), .pin_a_oe_o(pa_e),
    .pin_b_in_i(pin[15:8]), .pin_b_out_o(pb_o), .pin_b_oe_o(pb_e),
    .pin_c_in_i(pc_i), .pin_c_out_o(pc_o), .pin_c_oe_o(pc_e),
    .pin_d_in_i(pin[25:22]), .pin_d_out_o(pd_o), .pin_d_oe_o(pd_e),
    .gpio_dout_i(dout), .gpio_dir_i(dir), .gpio_periph_en_i(en),
    .gpio_din_o(din), .pin_group_select_reg_i(sel),
    .reset_pin_release_i(rr), .test_port_release_i(rt),
    .reset_pin_owned_o(own_r), .test_port_owned_o(own_t),
    .ext_reset_n_o(rst_n), .alt_out_i(a_out), .alt_oe_i(a_oe),
    .alt_in_o(a_in), .bad_sel_o(bad), .ext_clk_enable_i(ce),
    .external_clock_input_o(ck_in), .ext_clk_routed_o(ck_rt),
    .clk_conflict_o(ck_cf));

  task automatic chk(input logic [AW-1:0] got, input logic [AW-1:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t vector got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t flag got %b exp %b", $time, got, exp);
    end
  endtask

  // Reset functions of A7 and port D count as peripheral ownership
  function automatic logic pe_of(input int p);
    return en[p] | (p == PIN_A7 && !rr) | (p >= BASE_D && !rt);
  endfunction

  // Codes past the pin's alternatives fold to the first one
  function automatic int alt_of(input int p);
    logic [SEL_W-1:0] c;
    c = sel[p*SEL_W +: SEL_W];
    return (c >= ALT_COUNT[p]) ? 0 : int'(c);
  endfunction

  function automatic logic [AW-1:0] rnd();
    return AW'({$random(seed), $random(seed), $random(seed)});
  endfunction

  task automatic check_cycle();
    logic [NUM_PINS-1:0] eo, ee, eb;
    logic [AW-1:0] ea;
    logic b5, b6, route;
    int a;
    ea = '0;
    for (int p = 0; p < NUM_PINS; p++)
    begin
      a = alt_of(p);
      eo[p] = pe_of(p) ? a_out[p*NALT+a] : dout[p];
      ee[p] = pe_of(p) ? a_oe[p*NALT+a] : dir[p];
      eb[p] = pe_of(p) && (sel[p*SEL_W +: SEL_W] >= ALT_COUNT[p]);
      if (pe_of(p))
        ea[p*NALT+a] = h_pin[2][p];
    end
    b5 = pe_of(PIN_B5) && sel[PIN_B5*SEL_W +: SEL_W] == ALT_EXTERNAL_CLOCK_INPUT;
    b6 = pe_of(PIN_B6) && sel[PIN_B6*SEL_W +: SEL_W] == ALT_EXTERNAL_CLOCK_INPUT;
    route = ce && (b5 || b6);
    chk(AW'(f_out), AW'(eo));
    chk(AW'(f_oe), AW'(ee));
    chk(AW'(din), AW'(h_pin[1]));
    chk(a_in, ea);
    chk(AW'(bad), AW'(eb));
    chk(AW'({pc_o[3], pc_e[3]}), '0);
    chk_bit(own_r, !rr);
    chk_bit(own_t, !rt);
    chk_bit(ck_rt, route);
    chk_bit(ck_in, route & (b5 ? h_pin[2][PIN_B5] : h_pin[2][PIN_B6]));
    chk_bit(ck_cf, b5 && b6);
    chk_bit(rst_n, rr ? 1'b1 : h_pin[2][PIN_A7]);
  endtask

  // One cycle: check settled outputs, then drive new data off the edge
  task automatic step(input logic load);
    @(negedge clk_i);
    if (cnt >= 3)
      check_cycle();
    if (load)
    begin
      en = n_en;
      sel = n_sel;
      rr = n_rr;
      rt = n_rt;
      ce = n_ce;
      cnt = 0;
    end
    dout = NUM_PINS'(rnd());
    dir = NUM_PINS'(rnd());
    ext = NUM_PINS'(rnd());
    a_out = rnd();
    a_oe = rnd();
    #1;
    h_pin[2] = h_pin[1];
    h_pin[1] = h_pin[0];
    h_pin[0] = pin;
    cnt++;
  endtask

  task automatic run_block();
    step(1'b1);
    repeat (7) step(1'b0);
  endtask

  task automatic do_reset();
    @(negedge clk_i);
    sys_rst_i = 1'b1;
    repeat (6) @(negedge clk_i);
    chk_bit(own_r, 1'b1);
    chk_bit(own_t, 1'b1);
    chk_bit(rst_n, 1'b1);
    chk(AW'(f_oe), '0);
    chk(a_in, '0);
    sys_rst_i = 1'b0;
    cnt = 0;
  endtask

  task automatic test_done();
    if (fail_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    #(WD_CYCLES * 8);
    fail_count++;
    test_done();
  end

  initial
  begin
    do_reset();
    // Reset functions still own A7 and port D
    n_sel = (NUM_PINS*SEL_W)'(rnd());
    run_block();
    // Every select code on every pin, code 3 out of range
    for (int c = 0; c < 4; c++)
    begin
      n_en = '1;
      n_sel = {NUM_PINS{2'(c)}};
      n_rr = 1'b1;
      n_rt = 1'b1;
      n_ce = 1'b1;
      run_block();
    end
    // Select without peripheral hand-over must not steer
    n_en = '0;
    n_sel = (NUM_PINS*SEL_W)'(rnd());
    run_block();
    repeat (40)
    begin
      n_en = NUM_PINS'(rnd());
      n_sel = (NUM_PINS*SEL_W)'(rnd());
      {n_rr, n_rt, n_ce} = 3'(rnd());
      run_block();
    end
    do_reset();
    run_block();
    test_done();
  end
endmodule
`default_nettype wire

// ==== verilog/input_sync.sv ====
// Two-stage synchroniser for package pin inputs.
// Assumes pins are asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Data
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  import pin_mux_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t q;
  sync_state_t d;

  // First stage feeds only the second
  always_comb
  begin
    d.meta = async_i;
    d.stable = q.meta;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      q <= '{meta: {W{PIN_RST}}, stable: {W{PIN_RST}}};
    else
      q <= d;
  end

  assign sync_o = q.stable;
endmodule
`default_nettype wire

// ==== verilog/pin_mux_pkg.sv ====
// Constants for the port pin function router.
// Assumes one system clock and a synchronous reset.
package pin_mux_pkg;
  // Flat pin index: A0-A7, B0-B7, C0-C2, C4-C6, D0-D3
  localparam int NUM_PINS = 26;
  localparam int NALT = 3;
  localparam int SEL_W = 2;
  localparam int PORT_A_W = 8;
  localparam int PORT_B_W = 8;
  localparam int PORT_C_W = 7;
  localparam int PORT_D_W = 4;
  localparam int PORT_C_HOLE = 3;
  localparam int C_LOW_N = 3;
  localparam int BASE_A = 0;
  localparam int BASE_B = 8;
  localparam int BASE_C = 16;
  localparam int BASE_D = 22;
  localparam int PIN_A4 = 4;
  localparam int PIN_A5 = 5;
  localparam int PIN_A6 = 6;
  localparam int PIN_A7 = 7;
  localparam int PIN_B0 = 8;
  localparam int PIN_B1 = 9;
  localparam int PIN_B2 = 10;
  localparam int PIN_B3 = 11;
  localparam int PIN_B4 = 12;
  localparam int PIN_B5 = 13;
  localparam int PIN_B6 = 14;
  localparam int PIN_B7 = 15;
  localparam int PIN_C2 = 18;
  localparam int PIN_C4 = 19;
  localparam int PIN_C6 = 21;
  localparam int PIN_D1 = 23;
  localparam logic [SEL_W-1:0] ALT_FIRST = 2'h0;
  localparam logic [SEL_W-1:0] ALT_SECOND = 2'h1;
  localparam logic [SEL_W-1:0] ALT_THIRD = 2'h2;
  localparam logic [SEL_W-1:0] ALT_EXTERNAL_CLOCK_INPUT = 2'h2;
  // Alternatives per pin, in select order:
  // A0-A3 pulse out; A4 pulse_out_4/timer_a_chan2/fault_in_1
  // A5 pulse_out_5/timer_a_chan3/fault_in_2; A6 fault_in_0/timer_a_chan0
  // A7 external reset; B0 qserial_clock/scl; B1 qserial_slave_select/sda
  // B2 qserial_data_in/timer_a_chan2/pulse_source_in_0
  // B3 qserial_data_out/timer_a_chan3/pulse_source_in_1
  // B4 timer_a_chan0/clock_output_pin/pulse_source_in_2
  // B5 timer_a_chan1/fault_in_3/external_clock_input
  // B6 async_serial_receive/sda/external_clock_input
  // B7 async_serial_transmit/scl; C2 analog_in_a2/converter_a_high_ref
  // C4 analog_in_b0/comparator_b_input3; C6 analog_in_b2/converter_b_high_ref
  // D0-D3 test port
  localparam logic [SEL_W-1:0] ALT_COUNT [NUM_PINS] = '{
    2'h1, 2'h1, 2'h1, 2'h1, 2'h3, 2'h3, 2'h2, 2'h1,
    2'h2, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h2,
    2'h1, 2'h1, 2'h2, 2'h2, 2'h1, 2'h2,
    2'h1, 2'h1, 2'h1, 2'h1};
  localparam logic PIN_RST = 1'b0;
  localparam logic OWN_RST = 1'b1;
  localparam logic RESET_IDLE = 1'b1;
endpackage

// ==== verilog/pin_route_cell.sv ====
// One pin's router between port logic and its peripheral alternatives.
// Assumes pin_i is already synchronised; select comes from clk_i logic.
`timescale 1ns/1ps
`default_nettype none
module pin_route_cell #(
  parameter int NALT = 3,
  parameter int SEL_W = 2,
  parameter logic [SEL_W-1:0] NCNT = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Control
  input wire logic [SEL_W-1:0] sel_i,
  input wire logic periph_i,
  input wire logic gpio_dout_i,
  input wire logic gpio_dir_i,
  input wire logic pin_i,
  // Peripheral side
  input wire logic [NALT-1:0] alt_out_i,
  input wire logic [NALT-1:0] alt_oe_i,
  output logic [NALT-1:0] alt_in_o,
  // Pin side
  output logic pin_out_o,
  output logic pin_oe_o,
  output logic bad_sel_o
);
  import pin_mux_pkg::*;

  typedef struct packed {
    logic out;
    logic oe;
    logic bad;
    logic [NALT-1:0] alt_in;
  } cell_state_t;

  cell_state_t q;
  cell_state_t d;
  logic [SEL_W-1:0] eff_sel;

  // Unused codes fall back to the first alternative
  always_comb
  begin
    eff_sel = (sel_i < NCNT) ? sel_i : ALT_FIRST;
    d.bad = periph_i && (sel_i >= NCNT);
    if (periph_i)
    begin
      d.out = alt_out_i[eff_sel];
      d.oe = alt_oe_i[eff_sel];
      d.alt_in = NALT'(pin_i) << eff_sel;
    end
    else
    begin
      d.out = gpio_dout_i;
      d.oe = gpio_dir_i;
      d.alt_in = '0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      q <= '{out: PIN_RST, oe: PIN_RST, bad: PIN_RST, alt_in: '0};
    else
      q <= d;
  end

  assign pin_out_o = q.out;
  assign pin_oe_o = q.oe;
  assign bad_sel_o = q.bad;
  assign alt_in_o = q.alt_in;
endmodule
`default_nettype wire

// ==== verilog/port_pin_mux.sv ====
// Top of the four-port pin function router.
// Assumes port logic, peripherals and the select word share clk_i;
// package pins are asynchronous and are synchronised here.
//
// What this block does
// - Ports A and B have 8 pins, C has 6 (no bit 3), D has 4.
// - After reset A7 is external reset, D0-D3 test port, rest plain I/O.
// - A4 goes to pulse_out_4, timer_a_chan2 or fault_in_1 by select.
// - A5 goes to pulse_out_5, timer_a_chan3 or fault_in_2 by select.
// - A6 goes to fault_in_0 or timer_a_chan0 by select.
// - B0 carries qserial_clock or two-wire clock by select.
// - B1 carries qserial_slave_select or two-wire data by select.
// - B2 carries qserial_data_in, timer_a_chan2 or pulse_source_in_0.
// - B3 carries qserial_data_out, timer_a_chan3 or pulse_source_in_1.
// - B4 carries timer_a_chan0, clock_output_pin or pulse_source_in_2.
// - B5 carries timer_a_chan1, fault_in_3 or external_clock_input.
// - B6 carries async_serial_receive, two-wire data or external clock.
// - B7 carries async_serial_transmit or two-wire clock by select.
// - External clock on B5/B6 works only when the clock generator allows.
// - C2 goes to analog_in_a2 or converter_a_high_ref by select.
// - C4 goes to analog_in_b0 or comparator_b_input3 by select.
// - C6 goes to analog_in_b2 or converter_b_high_ref by select.
`timescale 1ns/1ps
`default_nettype none
module port_pin_mux (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Package pins
  input wire logic [pin_mux_pkg::PORT_A_W-1:0] pin_a_in_i,
  output logic [pin_mux_pkg::PORT_A_W-1:0] pin_a_out_o,
  output logic [pin_mux_pkg::PORT_A_W-1:0] pin_a_oe_o,
  input wire logic [pin_mux_pkg::PORT_B_W-1:0] pin_b_in_i,
  output logic [pin_mux_pkg::PORT_B_W-1:0] pin_b_out_o,
  output logic [pin_mux_pkg::PORT_B_W-1:0] pin_b_oe_o,
  input wire logic [pin_mux_pkg::PORT_C_W-1:0] pin_c_in_i,
  output logic [pin_mux_pkg::PORT_C_W-1:0] pin_c_out_o,
  output logic [pin_mux_pkg::PORT_C_W-1:0] pin_c_oe_o,
  input wire logic [pin_mux_pkg::PORT_D_W-1:0] pin_d_in_i,
  output logic [pin_mux_pkg::PORT_D_W-1:0] pin_d_out_o,
  output logic [pin_mux_pkg::PORT_D_W-1:0] pin_d_oe_o,
  // Port logic, flat pin index
  input wire logic [pin_mux_pkg::NUM_PINS-1:0] gpio_dout_i,
  input wire logic [pin_mux_pkg::NUM_PINS-1:0] gpio_dir_i,
  input wire logic [pin_mux_pkg::NUM_PINS-1:0] gpio_periph_en_i,
  output logic [pin_mux_pkg::NUM_PINS-1:0] gpio_din_o,
  // Pin group select word
  input wire logic [pin_mux_pkg::NUM_PINS*pin_mux_pkg::SEL_W-1:0]
    pin_group_select_reg_i,
  // Reset-function release
  input wire logic reset_pin_release_i,
  input wire logic test_port_release_i,
  output logic reset_pin_owned_o,
  output logic test_port_owned_o,
  output logic ext_reset_n_o,
  // Peripheral alternatives, pin*NALT+alt
  input wire logic [pin_mux_pkg::NUM_PINS*pin_mux_pkg::NALT-1:0] alt_out_i,
  input wire logic [pin_mux_pkg::NUM_PINS*pin_mux_pkg::NALT-1:0] alt_oe_i,
  output logic [pin_mux_pkg::NUM_PINS*pin_mux_pkg::NALT-1:0] alt_in_o,
  output logic [pin_mux_pkg::NUM_PINS-1:0] bad_sel_o,
  // Clock generator
  input wire logic ext_clk_enable_i,
  output logic external_clock_input_o,
  output logic ext_clk_routed_o,
  output logic clk_conflict_o
);
  import pin_mux_pkg::*;

  typedef struct packed {
    logic reset_own;
    logic test_own;
    logic ext_reset_n;
    logic ext_clk;
    logic clk_routed;
    logic clk_conflict;
  } mux_state_t;

  mux_state_t q;
  mux_state_t d;

  logic [NUM_PINS-1:0] pin_raw;
  logic [NUM_PINS-1:0] pin_sync;
  logic [NUM_PINS-1:0] own_mask;
  logic [NUM_PINS-1:0] periph;
  logic [NUM_PINS-1:0] cell_out;
  logic [NUM_PINS-1:0] cell_oe;
  logic b5_external_clock_input;
  logic b6_external_clock_input;

  // Port C has no bit 3, so it is skipped in the flat index
  assign pin_raw = {pin_d_in_i,
                    pin_c_in_i[PORT_C_HOLE+1 +: C_LOW_N],
                    pin_c_in_i[0 +: C_LOW_N],
                    pin_b_in_i,
                    pin_a_in_i};

  input_sync #(
    .W(NUM_PINS)
  ) u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(pin_raw),
    .sync_o(pin_sync)
  );

  // Reset-function pins count as peripheral-owned until released
  always_comb
  begin
    own_mask = '0;
    own_mask[PIN_A7] = q.reset_own;
    own_mask[BASE_D +: PORT_D_W] = {PORT_D_W{q.test_own}};
    periph = gpio_periph_en_i | own_mask;
  end

  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p++)
    begin : g_pin
      pin_route_cell #(
        .NALT(NALT),
        .SEL_W(SEL_W),
        .NCNT(ALT_COUNT[p])
      ) u_cell (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .sel_i(pin_group_select_reg_i[p*SEL_W +: SEL_W]),
        .periph_i(periph[p]),
        .gpio_dout_i(gpio_dout_i[p]),
        .gpio_dir_i(gpio_dir_i[p]),
        .pin_i(pin_sync[p]),
        .alt_out_i(alt_out_i[p*NALT +: NALT]),
        .alt_oe_i(alt_oe_i[p*NALT +: NALT]),
        .alt_in_o(alt_in_o[p*NALT +: NALT]),
        .pin_out_o(cell_out[p]),
        .pin_oe_o(cell_oe[p]),
        .bad_sel_o(bad_sel_o[p])
      );
    end
  endgenerate

  // External clock: B5 wins if both pins pick it
  always_comb
  begin
    b5_external_clock_input = periph[PIN_B5] &&
      (pin_group_select_reg_i[PIN_B5*SEL_W +: SEL_W] == ALT_EXTERNAL_CLOCK_INPUT);
    b6_external_clock_input = periph[PIN_B6] &&
      (pin_group_select_reg_i[PIN_B6*SEL_W +: SEL_W] == ALT_EXTERNAL_CLOCK_INPUT);
    d.reset_own = !reset_pin_release_i;
    d.test_own = !test_port_release_i;
    d.ext_reset_n = q.reset_own ? pin_sync[PIN_A7] : RESET_IDLE;
    d.clk_routed = ext_clk_enable_i && (b5_external_clock_input || b6_external_clock_input);
    d.ext_clk = d.clk_routed &&
      (b5_external_clock_input ? pin_sync[PIN_B5] : pin_sync[PIN_B6]);
    d.clk_conflict = b5_external_clock_input && b6_external_clock_input;
  end

  // Reset hands A7 and port D to their reset functions
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      q <= '{reset_own: OWN_RST, test_own: OWN_RST,
             ext_reset_n: RESET_IDLE, ext_clk: PIN_RST,
             clk_routed: PIN_RST, clk_conflict: PIN_RST};
    else
      q <= d;
  end

  assign pin_a_out_o = cell_out[BASE_A +: PORT_A_W];
  assign pin_a_oe_o = cell_oe[BASE_A +: PORT_A_W];
  assign pin_b_out_o = cell_out[BASE_B +: PORT_B_W];
  assign pin_b_oe_o = cell_oe[BASE_B +: PORT_B_W];
  // Missing bit 3 never drives
  assign pin_c_out_o = {cell_out[BASE_C+C_LOW_N +: C_LOW_N], PIN_RST,
                        cell_out[BASE_C +: C_LOW_N]};
  assign pin_c_oe_o = {cell_oe[BASE_C+C_LOW_N +: C_LOW_N], PIN_RST,
                       cell_oe[BASE_C +: C_LOW_N]};
  assign pin_d_out_o = cell_out[BASE_D +: PORT_D_W];
  assign pin_d_oe_o = cell_oe[BASE_D +: PORT_D_W];
  assign gpio_din_o = pin_sync;
  assign reset_pin_owned_o = q.reset_own;
  assign test_port_owned_o = q.test_own;
  assign ext_reset_n_o = q.ext_reset_n;
  assign external_clock_input_o = q.ext_clk;
  assign ext_clk_routed_o = q.clk_routed;
  assign clk_conflict_o = q.clk_conflict;

  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_port_c_hole: assert property (
    !pin_c_oe_o[PORT_C_HOLE] && !pin_c_out_o[PORT_C_HOLE])
    else $error("port C bit 3 is driven");

  // Ownership lags release by one edge, the cell flop by one more
  a_reset_pin_owned: assert property (
    !reset_pin_release_i ##1 !reset_pin_release_i
      |=> reset_pin_owned_o
      ##0 (pin_a_out_o[PIN_A7] == $past(alt_out_i[PIN_A7*NALT])))
    else $error("A7 not held by reset function");

  a_test_port_drive: assert property (
    !test_port_release_i ##1 !test_port_release_i
      |=> test_port_owned_o
      ##0 (pin_d_oe_o[PIN_D1-BASE_D] == $past(alt_oe_i[PIN_D1*NALT])))
    else $error("test port output not routed");

  a_a4_timer_route: assert property (
    periph[PIN_A4] &&
      pin_group_select_reg_i[PIN_A4*SEL_W +: SEL_W] == ALT_SECOND
      |=> pin_a_out_o[PIN_A4] == $past(alt_out_i[PIN_A4*NALT+1]))
    else $error("A4 timer route wrong");

  a_a5_fault_in: assert property (
    (periph[PIN_A5] &&
      pin_group_select_reg_i[PIN_A5*SEL_W +: SEL_W] == ALT_THIRD) [*3]
      |=> alt_in_o[PIN_A5*NALT+2] == $past(pin_a_in_i[PIN_A5], 3))
    else $error("A5 fault input not delivered");

  a_a6_bad_code: assert property (
    periph[PIN_A6] &&
      pin_group_select_reg_i[PIN_A6*SEL_W +: SEL_W] == ALT_THIRD
      |=> bad_sel_o[PIN_A6] &&
          pin_a_out_o[PIN_A6] == $past(alt_out_i[PIN_A6*NALT]))
    else $error("A6 unused code not folded");

  a_b0_scl_route: assert property (
    periph[PIN_B0] &&
      pin_group_select_reg_i[PIN_B0*SEL_W +: SEL_W] == ALT_SECOND
      |=> pin_b_oe_o[PIN_B0-BASE_B] == $past(alt_oe_i[PIN_B0*NALT+1]))
    else $error("B0 two-wire clock not routed");

  a_b1_ss_route: assert property (
    periph[PIN_B1] &&
      pin_group_select_reg_i[PIN_B1*SEL_W +: SEL_W] == ALT_FIRST
      |=> pin_b_out_o[PIN_B1-BASE_B] == $past(alt_out_i[PIN_B1*NALT]))
    else $error("B1 slave select not routed");

  a_b2_one_hot: assert property (
    periph[PIN_B2] |=> $countones(alt_in_o[PIN_B2*NALT +: NALT]) <= 1)
    else $error("B2 input fans to two alternatives");

  a_b3_psrc_route: assert property (
    periph[PIN_B3] &&
      pin_group_select_reg_i[PIN_B3*SEL_W +: SEL_W] == ALT_THIRD
      |=> pin_b_out_o[PIN_B3-BASE_B] == $past(alt_out_i[PIN_B3*NALT+2]))
    else $error("B3 pulse source route wrong");

  a_b4_clkout: assert property (
    periph[PIN_B4] &&
      pin_group_select_reg_i[PIN_B4*SEL_W +: SEL_W] == ALT_SECOND
      |=> pin_b_out_o[PIN_B4-BASE_B] == $past(alt_out_i[PIN_B4*NALT+1]))
    else $error("B4 clock output not routed");

  a_b7_txd_route: assert property (
    periph[PIN_B7] &&
      pin_group_select_reg_i[PIN_B7*SEL_W +: SEL_W] == ALT_FIRST
      |=> pin_b_out_o[PIN_B7-BASE_B] == $past(alt_out_i[PIN_B7*NALT]))
    else $error("B7 transmit not routed");

  a_external_clock_input_enable: assert property (
    ext_clk_routed_o |-> $past(ext_clk_enable_i))
    else $error("external clock routed without enable");

  a_external_clock_input_quiet: assert property (
    !ext_clk_enable_i |=> !ext_clk_routed_o && !external_clock_input_o)
    else $error("external clock passes while disabled");

  a_b6_external_clock_input_data: assert property (
    b6_external_clock_input && !b5_external_clock_input && ext_clk_enable_i
      |=> external_clock_input_o == $past(pin_sync[PIN_B6]))
    else $error("B6 external clock value wrong");

  a_c2_ref_oe: assert property (
    periph[PIN_C2] &&
      pin_group_select_reg_i[PIN_C2*SEL_W +: SEL_W] == ALT_SECOND
      |=> pin_c_oe_o[PIN_C2-BASE_C] == $past(alt_oe_i[PIN_C2*NALT+1]))
    else $error("C2 reference enable wrong");

  a_c4_gpio_hold: assert property (
    !periph[PIN_C4] |=>
      pin_c_out_o[PORT_C_HOLE+1] == $past(gpio_dout_i[PIN_C4]) &&
      pin_c_oe_o[PORT_C_HOLE+1] == $past(gpio_dir_i[PIN_C4]))
    else $error("C4 left port control");

  a_c6_ref_in: assert property (
    periph[PIN_C6] &&
      pin_group_select_reg_i[PIN_C6*SEL_W +: SEL_W] == ALT_SECOND
      |=> !alt_in_o[PIN_C6*NALT])
    else $error("C6 first alternative still fed");

  a_gpio_no_alt: assert property (
    !periph[PIN_B5] |=> alt_in_o[PIN_B5*NALT +: NALT] == '0)
    else $error("select acted on a plain I/O pin");

  a_a4_fault_route: assert property (
    periph[PIN_A4] &&
      pin_group_select_reg_i[PIN_A4*SEL_W +: SEL_W] == ALT_THIRD
      |=> pin_a_out_o[PIN_A4] == $past(alt_out_i[PIN_A4*NALT+2]))
    else $error("A4 fault route wrong");

  a_a5_pulse_route: assert property (
    periph[PIN_A5] &&
      pin_group_select_reg_i[PIN_A5*SEL_W +: SEL_W] == ALT_FIRST
      |=> pin_a_oe_o[PIN_A5] == $past(alt_oe_i[PIN_A5*NALT]))
    else $error("A5 pulse output enable wrong");

  a_a6_timer_route: assert property (
    periph[PIN_A6] &&
      pin_group_select_reg_i[PIN_A6*SEL_W +: SEL_W] == ALT_SECOND
      |=> pin_a_out_o[PIN_A6] == $past(alt_out_i[PIN_A6*NALT+1]))
    else $error("A6 timer route wrong");

  a_b1_sda_oe: assert property (
    periph[PIN_B1] &&
      pin_group_select_reg_i[PIN_B1*SEL_W +: SEL_W] == ALT_SECOND
      |=> pin_b_oe_o[PIN_B1-BASE_B] == $past(alt_oe_i[PIN_B1*NALT+1]))
    else $error("B1 two-wire data enable wrong");

  a_b5_fault_oe: assert property (
    periph[PIN_B5] &&
      pin_group_select_reg_i[PIN_B5*SEL_W +: SEL_W] == ALT_SECOND
      |=> pin_b_oe_o[PIN_B5-BASE_B] == $past(alt_oe_i[PIN_B5*NALT+1]))
    else $error("B5 fault route wrong");

  a_b6_rxd_in: assert property (
    (periph[PIN_B6] &&
      pin_group_select_reg_i[PIN_B6*SEL_W +: SEL_W] == ALT_FIRST) [*3]
      |=> alt_in_o[PIN_B6*NALT] == $past(pin_b_in_i[PIN_B6-BASE_B], 3))
    else $error("B6 receive input not delivered");

  a_b5_external_clock_input_data: assert property (
    b5_external_clock_input && ext_clk_enable_i
      |=> external_clock_input_o == $past(pin_sync[PIN_B5]))
    else $error("B5 external clock value wrong");

  // Both pins on the clock is a setup error; B5 still wins
  a_clk_conflict: assert property (
    b5_external_clock_input && b6_external_clock_input |=> clk_conflict_o)
    else $error("external clock conflict not flagged");

  a_ext_reset_follow: assert property (
    reset_pin_owned_o |=> ext_reset_n_o == $past(pin_sync[PIN_A7]))
    else $error("external reset does not follow A7");

  a_ext_reset_idle: assert property (
    !reset_pin_owned_o |=> ext_reset_n_o)
    else $error("external reset active after release");

  a_c2_bad_plain: assert property (
    !periph[PIN_C2] |=> !bad_sel_o[PIN_C2])
    else $error("bad select flagged on a plain I/O pin");
endmodule
`default_nettype wire
